// ===== common/rca_pkg.sv
package rca_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_ALCTL = 8'h04;
    localparam logic [7:0] OFS_DATE  = 8'h08;
    localparam logic [7:0] OFS_ATIME = 8'h0C;
    localparam logic [7:0] OFS_ADATE = 8'h10;
    localparam logic [7:0] OFS_ISTAT = 8'h14;
    localparam logic [7:0] OFS_ICLR  = 8'h18;
    localparam logic [7:0] OFS_IEN   = 8'h1C;

    // Writable bits per register; all others read as zero
    localparam logic [31:0] CTRL_MASK  = 32'h0000_0008;
    localparam logic [31:0] ALCTL_MASK = 32'h0000_CFFF;
    localparam logic [31:0] DATE_MASK  = 32'hFF1F_3F07;
    localparam logic [31:0] ATIME_MASK = 32'h3F7F_7F00;
    localparam logic [31:0] ADATE_MASK = 32'h001F_3F07;
    localparam logic [31:0] IRQ_MASK   = 32'h0000_0003;

    // Field positions
    localparam int CTRL_WREN_BIT   = 3;
    localparam int ALCTL_EN_BIT    = 15;
    localparam int ALCTL_CHIME_BIT = 14;
    localparam int ALCTL_MASK_LSB  = 8;
    localparam int ALCTL_RPT_LSB   = 0;
    localparam int IRQ_ALARM_BIT   = 0;
    localparam int IRQ_REFUSE_BIT  = 1;
    localparam int WDAY_LSB        = 0;

    // Largest weekday value
    localparam logic [2:0] WDAY_MAX = 3'h6;

    // Reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // Alarm match mask codes
    localparam logic [3:0] AM_HALFSEC = 4'h0;
    localparam logic [3:0] AM_SEC     = 4'h1;
    localparam logic [3:0] AM_TENSEC  = 4'h2;
    localparam logic [3:0] AM_MIN     = 4'h3;
    localparam logic [3:0] AM_TENMIN  = 4'h4;
    localparam logic [3:0] AM_HOUR    = 4'h5;
    localparam logic [3:0] AM_DAY     = 4'h6;
    localparam logic [3:0] AM_WEEK    = 4'h7;
    localparam logic [3:0] AM_MONTH   = 4'h8;
    localparam logic [3:0] AM_YEAR    = 4'h9;

endpackage

// ===== rtl/rca_calendar_alarm.sv
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps

module rca_calendar_alarm
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // Running time from the timekeeper
    input  wire logic        SEC_TICK,
    input  wire logic [31:0] RUN_TIME,
    // Events
    output logic             ALARM_EVT,
    output logic             IRQ
);

    logic        ack_q;
    logic [31:0] rdat_q;
    logic        irq_q;
    logic        evt_q;
    logic [31:0] ctrl_q;
    logic [31:0] date_q;
    logic [31:0] atime_q;
    logic [31:0] adate_q;
    logic        alm_en_q;
    logic        chime_q;
    logic [3:0]  alarm_match_mask_q;
    logic [7:0]  rpt_q;
    logic [1:0]  istat_q;
    logic [1:0]  ien_q;
    logic [1:0]  istat_d;
    logic [31:0] wmerge;
    logic [31:0] rd_mux;
    logic        req;
    logic        wr_go;
    logic        wr_ctrl;
    logic        wr_alctl;
    logic        wr_date;
    logic        wr_atime;
    logic        wr_adate;
    logic        wr_iclr;
    logic        wr_ien;
    logic        wren;
    logic        refuse;
    logic        match;
    logic        fire;
    logic [31:0] alctl_rd;
    logic [31:0] date_wv;
    logic [31:0] adate_wv;

    // Bus handshake
    assign req   = WB_CYC_I & WB_STB_I;
    assign wr_go = req & WB_WE_I & ack_q;
    assign wren  = ctrl_q[rca_pkg::CTRL_WREN_BIT];

    // Byte lane merge against the addressed register
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign wmerge[8*gi +: 8] = WB_SEL_I[gi] ? WB_DAT_I[8*gi +: 8] : rd_mux[8*gi +: 8];
        end
    endgenerate

    // Address decode
    assign wr_ctrl  = wr_go && (WB_ADR_I == rca_pkg::OFS_CTRL);
    assign wr_alctl = wr_go && (WB_ADR_I == rca_pkg::OFS_ALCTL);
    assign wr_date  = wr_go && (WB_ADR_I == rca_pkg::OFS_DATE) && wren;
    assign refuse   = wr_go && (WB_ADR_I == rca_pkg::OFS_DATE) && !wren;
    assign wr_atime = wr_go && (WB_ADR_I == rca_pkg::OFS_ATIME);
    assign wr_adate = wr_go && (WB_ADR_I == rca_pkg::OFS_ADATE);
    assign wr_iclr  = wr_go && (WB_ADR_I == rca_pkg::OFS_ICLR);
    assign wr_ien   = wr_go && (WB_ADR_I == rca_pkg::OFS_IEN);

    assign alctl_rd = {16'h0000, alm_en_q, chime_q, 2'h0, alarm_match_mask_q, rpt_q};

    // Read multiplexer
    always_comb
    begin
        unique case (WB_ADR_I)
            rca_pkg::OFS_CTRL:  rd_mux = ctrl_q;
            rca_pkg::OFS_ALCTL: rd_mux = alctl_rd;
            rca_pkg::OFS_DATE:  rd_mux = date_q;
            rca_pkg::OFS_ATIME: rd_mux = atime_q;
            rca_pkg::OFS_ADATE: rd_mux = adate_q;
            rca_pkg::OFS_ISTAT: rd_mux = {30'h0, istat_q};
            rca_pkg::OFS_IEN:   rd_mux = {30'h0, ien_q};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // Ack one cycle after the request, data with it
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ack_q  <= 1'b0;
            rdat_q <= rca_pkg::REG_RESET;
        end
        else
        begin
            ack_q  <= req & ~ack_q;
            rdat_q <= (req & ~ack_q & ~WB_WE_I) ? rd_mux : 32'h0000_0000;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdat_q;

    // Control register
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            ctrl_q <= rca_pkg::REG_RESET;
        else if (wr_ctrl)
            ctrl_q <= wmerge & rca_pkg::CTRL_MASK;
    end

    // Weekday clamp on write
    always_comb
    begin
        date_wv  = wmerge & rca_pkg::DATE_MASK;
        adate_wv = wmerge & rca_pkg::ADATE_MASK;
        if (date_wv[2:0] > rca_pkg::WDAY_MAX)
            date_wv[2:0] = rca_pkg::WDAY_MAX;
        if (adate_wv[2:0] > rca_pkg::WDAY_MAX)
            adate_wv[2:0] = rca_pkg::WDAY_MAX;
    end

    // Calendar date
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            date_q <= rca_pkg::REG_RESET;
        else if (wr_date)
            date_q <= date_wv;
    end

    // Alarm time
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            atime_q <= rca_pkg::REG_RESET;
        else if (wr_atime)
            atime_q <= wmerge & rca_pkg::ATIME_MASK;
    end

    // Alarm date
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            adate_q <= rca_pkg::REG_RESET;
        else if (wr_adate)
            adate_q <= adate_wv;
    end

    // Field compare, selected by mask code
    always_comb
    begin
        logic sec_u;
        logic sec_f;
        logic min_u;
        logic min_f;
        logic hr_f;
        logic wd_f;
        logic md_f;
        logic mo_f;
        sec_u = RUN_TIME[11:8] == atime_q[11:8];
        sec_f = RUN_TIME[14:8] == atime_q[14:8];
        min_u = RUN_TIME[19:16] == atime_q[19:16];
        min_f = RUN_TIME[22:16] == atime_q[22:16];
        hr_f  = RUN_TIME[29:24] == atime_q[29:24];
        wd_f  = date_q[2:0] == adate_q[2:0];
        md_f  = date_q[13:8] == adate_q[13:8];
        mo_f  = date_q[20:16] == adate_q[20:16];
        case (alarm_match_mask_q)
            rca_pkg::AM_HALFSEC: match = 1'b1;
            rca_pkg::AM_SEC:     match = 1'b1;
            rca_pkg::AM_TENSEC:  match = sec_u;
            rca_pkg::AM_MIN:     match = sec_f;
            rca_pkg::AM_TENMIN:  match = min_u & sec_f;
            rca_pkg::AM_HOUR:    match = min_f & sec_f;
            rca_pkg::AM_DAY:     match = hr_f & min_f & sec_f;
            rca_pkg::AM_WEEK:    match = wd_f & hr_f & min_f & sec_f;
            rca_pkg::AM_MONTH:   match = md_f & hr_f & min_f & sec_f;
            rca_pkg::AM_YEAR:    match = mo_f & md_f & hr_f & min_f & sec_f;
            default:             match = 1'b0;
        endcase
    end

    assign fire = SEC_TICK & alm_en_q & match;

    // Alarm control: software write wins over hardware update
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            alm_en_q <= 1'b0;
            chime_q  <= 1'b0;
            alarm_match_mask_q  <= 4'h0;
            rpt_q    <= 8'h00;
        end
        else if (wr_alctl)
        begin
            alm_en_q <= wmerge[rca_pkg::ALCTL_EN_BIT];
            chime_q  <= wmerge[rca_pkg::ALCTL_CHIME_BIT];
            alarm_match_mask_q  <= wmerge[rca_pkg::ALCTL_MASK_LSB +: 4];
            rpt_q    <= wmerge[rca_pkg::ALCTL_RPT_LSB +: 8];
        end
        else if (fire)
        begin
            if (rpt_q != 8'h00 || chime_q)
                rpt_q <= rpt_q - 8'h01;
            if (rpt_q == 8'h00 && !chime_q)
                alm_en_q <= 1'b0;
        end
    end

    // Alarm event pulse
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            evt_q <= 1'b0;
        else
            evt_q <= fire;
    end

    assign ALARM_EVT = evt_q;

    // Sticky status; a new event beats a clear in the same cycle
    always_comb
    begin
        istat_d = istat_q;
        if (wr_iclr)
            istat_d = istat_q & ~wmerge[1:0];
        if (fire)
            istat_d[rca_pkg::IRQ_ALARM_BIT] = 1'b1;
        if (refuse)
            istat_d[rca_pkg::IRQ_REFUSE_BIT] = 1'b1;
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            istat_q <= 2'h0;
        else
            istat_q <= istat_d;
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            ien_q <= 2'h0;
        else if (wr_ien)
            ien_q <= wmerge[1:0];
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            irq_q <= 1'b0;
        else
            irq_q <= |(istat_d & ien_q);
    end

    assign IRQ = irq_q;

    // Checks
    date_rsv_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (date_q & ~rca_pkg::DATE_MASK) == 32'h0)
        else $error("date reserved bits set");

    atime_rsv_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (atime_q & ~rca_pkg::ATIME_MASK) == 32'h0)
        else $error("alarm time reserved bits set");

    adate_rsv_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (adate_q & ~rca_pkg::ADATE_MASK) == 32'h0)
        else $error("alarm date reserved bits set");

    date_locked_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        refuse |=> $stable(date_q))
        else $error("date changed while write enable clear");

    year_write_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (wr_date && WB_SEL_I[3]) |=> date_q[31:24] == $past(WB_DAT_I[31:24]))
        else $error("year digits not stored");

    month_write_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (wr_date && WB_SEL_I[2]) |=> date_q[20:16] == $past(WB_DAT_I[20:16]))
        else $error("month not stored");

    mday_write_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (wr_date && WB_SEL_I[1]) |=> date_q[13:8] == $past(WB_DAT_I[13:8]))
        else $error("day of month not stored");

    wday_range_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        date_q[2:0] <= rca_pkg::WDAY_MAX)
        else $error("weekday out of range");

    awday_range_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        adate_q[2:0] <= rca_pkg::WDAY_MAX)
        else $error("alarm weekday out of range");

    atime_write_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (wr_atime && WB_SEL_I == 4'hF)
        |=> atime_q == ($past(WB_DAT_I) & rca_pkg::ATIME_MASK))
        else $error("alarm time not stored");

    amonth_write_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (wr_adate && WB_SEL_I[2]) |=> adate_q[20:16] == $past(WB_DAT_I[20:16]))
        else $error("alarm month not stored");

    oneshot_off_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (fire && rpt_q == 8'h00 && !chime_q && !wr_alctl) |=> !alm_en_q)
        else $error("one-shot alarm stayed enabled");

    alarm_cause_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ALARM_EVT |-> $past(SEC_TICK) && $past(alm_en_q) && $past(match))
        else $error("alarm event without match");

    minute_match_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (SEC_TICK && alm_en_q && alarm_match_mask_q == rca_pkg::AM_MIN
         && RUN_TIME[14:8] != atime_q[14:8]) |=> !ALARM_EVT)
        else $error("minute alarm fired on wrong second");

    ack_pulse_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    irq_follow_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (fire && ien_q[rca_pkg::IRQ_ALARM_BIT]) |=> IRQ [*2])
        else $error("interrupt not raised on enabled alarm");

    ack_latency_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (req && !ack_q) |=> WB_ACK_O)
        else $error("ack not given one cycle after request");

    refuse_flag_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        refuse |=> istat_q[rca_pkg::IRQ_REFUSE_BIT])
        else $error("refused date write not flagged");

    alarm_status_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        fire |=> istat_q[rca_pkg::IRQ_ALARM_BIT])
        else $error("alarm status not set on event");

    reserved_code_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (SEC_TICK && alarm_match_mask_q > rca_pkg::AM_YEAR) |=> !ALARM_EVT)
        else $error("reserved mask code raised an alarm");

endmodule

// ===== verif/rca_calendar_alarm_tb_top.sv
`timescale 1ns/1ps

module rca_calendar_alarm_tb_top;

    logic        sys_clk;
    logic        arst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack;
    logic        sec_tick;
    logic [31:0] run_time;
    logic        alarm_evt;
    logic        irq;
    int          err_count = 0;
    int          tests_run = 0;

    localparam logic [31:0] T_OK = 32'h2359_5900;
    localparam logic [31:0] D_OK = 32'h0012_3104;

    rca_calendar_alarm dut_u (
        .SYS_CLK  (sys_clk),
        .ARST_N   (arst_n),
        .WB_CYC_I (cyc),
        .WB_STB_I (stb),
        .WB_WE_I  (we),
        .WB_ADR_I (adr),
        .WB_SEL_I (sel),
        .WB_DAT_I (dat_i),
        .WB_DAT_O (dat_o),
        .WB_ACK_O (ack),
        .SEC_TICK (sec_tick),
        .RUN_TIME (run_time),
        .ALARM_EVT(alarm_evt),
        .IRQ      (irq)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One classic cycle; holds the request until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= s;
        dat_i <= d;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (ack !== 1'b1)
        begin
            err_count++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, 4'hF, q);
        check(q, exp);
    endtask

    // Second tick, event expected one cycle later
    task automatic tick(input logic [31:0] t, input logic exp);
        @(posedge sys_clk);
        sec_tick <= 1'b1;
        run_time <= t;
        @(posedge sys_clk);
        sec_tick <= 1'b0;
        #1;
        check({31'h0, alarm_evt}, {31'h0, exp});
    endtask

    task automatic reset_vals;
        rd(rca_pkg::OFS_DATE, 32'h0000_0000);
        rd(rca_pkg::OFS_ATIME, 32'h0000_0000);
        rd(rca_pkg::OFS_ADATE, 32'h0000_0000);
        rd(rca_pkg::OFS_ISTAT, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
    endtask

    task automatic date_guard;
        logic [31:0] q;
        wr(rca_pkg::OFS_DATE, 32'h2024_0503);
        rd(rca_pkg::OFS_DATE, 32'h0000_0000);
        rd(rca_pkg::OFS_ISTAT, 32'h0000_0002);
        wr(rca_pkg::OFS_ICLR, 32'h0000_0002);
        rd(rca_pkg::OFS_ISTAT, 32'h0000_0000);
        wr(rca_pkg::OFS_CTRL, 32'h0000_0008);
        wr(rca_pkg::OFS_DATE, 32'hFFFF_FFFF);
        rd(rca_pkg::OFS_DATE, 32'hFF1F_3F06);
        wr(rca_pkg::OFS_DATE, 32'h9912_3106);
        rd(rca_pkg::OFS_DATE, 32'h9912_3106);
        wb(1'b1, rca_pkg::OFS_DATE, 32'hFFFF_FF04, 4'h1, q);
        rd(rca_pkg::OFS_DATE, 32'h9912_3104);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        rd(8'h09, 32'h0000_0000);
        wr(rca_pkg::OFS_CTRL, 32'h0000_0000);
        wr(rca_pkg::OFS_DATE, 32'h0101_0101);
        rd(rca_pkg::OFS_DATE, 32'h9912_3104);
        rd(rca_pkg::OFS_DATE, 32'h9912_3104);
        rd(rca_pkg::OFS_DATE, 32'h9912_3104);
        wr(rca_pkg::OFS_ICLR, 32'h0000_0003);
    endtask

    task automatic alarm_regs;
        wr(rca_pkg::OFS_ATIME, 32'hFFFF_FFFF);
        rd(rca_pkg::OFS_ATIME, 32'h3F7F_7F00);
        wr(rca_pkg::OFS_ADATE, 32'hFFFF_FFFF);
        rd(rca_pkg::OFS_ADATE, 32'h001F_3F06);
        wr(rca_pkg::OFS_ATIME, T_OK);
        rd(rca_pkg::OFS_ATIME, T_OK);
        wr(rca_pkg::OFS_ADATE, D_OK);
        rd(rca_pkg::OFS_ADATE, D_OK);
    endtask

    // Each code 0 to 9 fires on a full match and ignores only unselected fields; codes 10 to 15 never fire
    task automatic mask_codes;
        logic [3:0]  code [10] = '{4'h1, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
                                   4'h0, 4'h2, 4'h4};
        logic [31:0] bad_t[10] = '{32'h2359_5800, 32'h2359_5800, 32'h2358_5900,
                                   32'h2259_5900, T_OK, T_OK, T_OK,
                                   32'h0000_0000, 32'h2359_5800, 32'h2358_5900};
        logic [31:0] bad_d[10] = '{D_OK, D_OK, D_OK, D_OK, 32'h0012_3105,
                                   32'h0012_3004, 32'h0002_3104,
                                   D_OK, D_OK, D_OK};
        logic        bad_e[10] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                   1'b1, 1'b0, 1'b0};
        wr(rca_pkg::OFS_IEN, 32'h0000_0001);
        for (int i = 0; i < 10; i++)
        begin
            wr(rca_pkg::OFS_ALCTL, {16'h0000, 4'h8, code[i], 8'hFF});
            tick(T_OK, 1'b1);
            rd(rca_pkg::OFS_ISTAT, 32'h0000_0001);
            check({31'h0, irq}, 32'h0000_0001);
            wr(rca_pkg::OFS_ICLR, 32'h0000_0001);
            rd(rca_pkg::OFS_ISTAT, 32'h0000_0000);
            check({31'h0, irq}, 32'h0000_0000);
            wr(rca_pkg::OFS_ADATE, bad_d[i]);
            tick(bad_t[i], bad_e[i]);
            wr(rca_pkg::OFS_ADATE, D_OK);
            wr(rca_pkg::OFS_ICLR, 32'h0000_0001);
        end
        for (int c = 10; c < 16; c++)
        begin
            wr(rca_pkg::OFS_ALCTL, {16'h0000, 4'h8, c[3:0], 8'hFF});
            tick(T_OK, 1'b0);
        end
        wr(rca_pkg::OFS_ALCTL, 32'h0000_03FF);
        tick(T_OK, 1'b0);
    endtask

    task automatic repeat_stop;
        wr(rca_pkg::OFS_IEN, 32'h0000_0000);
        wr(rca_pkg::OFS_ALCTL, 32'h0000_8300);
        tick(T_OK, 1'b1);
        rd(rca_pkg::OFS_ALCTL, 32'h0000_0300);
        check({31'h0, irq}, 32'h0000_0000);
        tick(T_OK, 1'b0);
        wr(rca_pkg::OFS_ALCTL, 32'h0000_C300);
        tick(T_OK, 1'b1);
        rd(rca_pkg::OFS_ALCTL, 32'h0000_C3FF);
        wr(rca_pkg::OFS_ALCTL, 32'h0000_8301);
        tick(T_OK, 1'b1);
        rd(rca_pkg::OFS_ALCTL, 32'h0000_8300);
        wr(rca_pkg::OFS_IEN, 32'h0000_0001);
        rd(rca_pkg::OFS_ISTAT, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0001);
    endtask

    initial
    begin
        arst_n   = 1'b0;
        cyc      = 1'b0;
        stb      = 1'b0;
        we       = 1'b0;
        adr      = 8'h00;
        sel      = 4'h0;
        dat_i    = 32'h0000_0000;
        sec_tick = 1'b0;
        run_time = 32'h0000_0000;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        reset_vals();
        date_guard();
        alarm_regs();
        mask_codes();
        repeat_stop();
        summarize();
    end

    initial
    begin
        repeat (50000) @(posedge sys_clk);
        err_count++;
        summarize();
    end

endmodule
